//--- common/sflash_pkg.sv
`default_nettype none
package sflash_pkg;

  // ****************************************************************
  // instruction opcodes
  // ****************************************************************
  localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_STATUS_READ   = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OPC_STATUS_WR_EN  = 8'h50;
  localparam logic [7:0] OPC_BYTE_PROGRAM  = 8'h02;
  localparam logic [7:0] OPC_AUTO_INC_PROG = 8'had;
  localparam logic [7:0] OPC_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OPC_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OPC_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OPC_CHIP_ERASE_A  = 8'h60;
  localparam logic [7:0] OPC_CHIP_ERASE_B  = 8'hc7;

  // ****************************************************************
  // status word layout and power-up value
  // ****************************************************************
  localparam int          ST_BUSY_POS  = 0;
  localparam int          ST_WEL_POS   = 1;
  localparam int          ST_BP_LSB    = 2;
  localparam int          ST_BP_MSB    = 5;
  localparam int          ST_AAI_POS   = 6;
  localparam int          ST_LOCK_POS  = 7;
  localparam logic [7:0]  STATUS_RESET = 8'h1c;
  localparam logic [3:0]  BP_RESET     = STATUS_RESET[ST_BP_MSB:ST_BP_LSB];

  // ****************************************************************
  // array geometry and array operation codes
  // ****************************************************************
  localparam int          ADDR_WIDTH   = 19;
  localparam logic [2:0]  OP_NONE      = 3'h0;
  localparam logic [2:0]  OP_BYTE_PROG = 3'h1;
  localparam logic [2:0]  OP_AAI_WORD  = 3'h2;
  localparam logic [2:0]  OP_SECTOR    = 3'h3;
  localparam logic [2:0]  OP_BLOCK32   = 3'h4;
  localparam logic [2:0]  OP_BLOCK64   = 3'h5;
  localparam logic [2:0]  OP_CHIP      = 3'h6;

  // ****************************************************************
  // internal operation durations in core_clk cycles
  // ****************************************************************
  localparam logic [23:0] PROG_CYCLES_DEF  = 24'h000040;
  localparam logic [23:0] ERASE_CYCLES_DEF = 24'h000400;
  localparam logic [23:0] CHIP_CYCLES_DEF  = 24'h001000;

endpackage
`default_nettype wire

//--- hw/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// two-flop synchroniser for a group of asynchronous pins
module pin_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // asynchronous pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta     <= '1;
      sync_out <= '1;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

//--- hw/serial_flash_status_protect.sv
`timescale 1ns/10ps
`default_nettype none

module serial_flash_status_protect
  import sflash_pkg::*;
#(
  parameter int          ADDR_W       = ADDR_WIDTH,
  parameter logic [23:0] PROG_CYCLES  = PROG_CYCLES_DEF,
  parameter logic [23:0] ERASE_CYCLES = ERASE_CYCLES_DEF,
  parameter logic [23:0] CHIP_CYCLES  = CHIP_CYCLES_DEF
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // serial pins, asynchronous to core_clk
  input  wire logic              cs_n,
  input  wire logic              sck,
  input  wire logic              si,
  input  wire logic              wp_n,
  output logic                   so,
  output logic                   so_en,
  // observed status word
  output logic [7:0]             status_word,
  // array operation request, one-cycle pulse
  output logic                   op_valid,
  output logic [2:0]             op_kind,
  output logic [ADDR_W-1:0]      op_addr,
  output logic [15:0]            op_data
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [2:0] {F_IDLE, F_OPCODE, F_PAYLOAD, F_STATUS, F_DISCARD} frame_t;

  typedef struct packed {
    frame_t            frame;
    logic [2:0]        bit_cnt;
    logic [2:0]        rx_cnt;
    logic [7:0]        shift;
    logic [7:0]        opcode;
    logic [39:0]       payload;
    logic [2:0]        obit;
    logic [7:0]        out_sh;
    logic              so;
    logic              so_en;
    logic              sck_d;
    logic              busy;
    logic              write_enable_latch;
    logic              auto_increment_program_mode;
    logic              lock;
    logic [3:0]        bp;
    logic              ewsr;
    logic [23:0]       timer;
    logic              clr_wel_done;
    logic              aai_exit;
    logic [ADDR_W-1:0] aai_addr;
    logic              op_valid;
    logic [2:0]        op_kind;
    logic [ADDR_W-1:0] op_addr;
    logic [15:0]       op_data;
  } state_t;

  state_t s;
  state_t next_s;

  logic [3:0] pins;
  logic       cs_q;
  logic       sck_q;
  logic       si_q;
  logic       wp_q;

  pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({cs_n, sck, si, wp_n}),
    .sync_out (pins)
  );

  assign {cs_q, sck_q, si_q, wp_q} = pins;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // protected range for a level code; top level bit is ignored
  function automatic logic prot_hit(input logic [3:0] lvl, input logic [ADDR_W-1:0] a);
    case (lvl[2:0])
      3'h0:    prot_hit = 1'b0;
      3'h1:    prot_hit = &a[ADDR_W-1:ADDR_W-3];
      3'h2:    prot_hit = &a[ADDR_W-1:ADDR_W-2];
      3'h3:    prot_hit = a[ADDR_W-1];
      default: prot_hit = 1'b1;
    endcase
  endfunction

  // payload bytes expected after the opcode; 7 never completes
  function automatic logic [2:0] need_bytes(input logic [7:0] opc, input logic in_aai);
    case (opc)
      OPC_WRITE_ENABLE, OPC_WRITE_DISABLE, OPC_STATUS_WR_EN,
      OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B:                  need_bytes = 3'h0;
      OPC_STATUS_WRITE:                                    need_bytes = 3'h1;
      OPC_SECTOR_ERASE, OPC_BLOCK32_ERASE, OPC_BLOCK64_ERASE: need_bytes = 3'h3;
      OPC_BYTE_PROGRAM:                                    need_bytes = 3'h4;
      OPC_AUTO_INC_PROG:                                   need_bytes = in_aai ? 3'h2 : 3'h5;
      default:                                             need_bytes = 3'h7;
    endcase
  endfunction

  function automatic logic [7:0] pack_status(input state_t st);
    pack_status = {st.lock, st.auto_increment_program_mode, st.bp, st.write_enable_latch, st.busy};
  endfunction

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    logic              sck_rise;
    logic              sck_fall;
    logic [7:0]        sh;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] tgt;
    logic              start;
    logic [7:0]        st_now;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    sh       = '0;
    addr     = '0;
    tgt      = '0;
    start    = 1'b0;
    st_now   = pack_status(s);
    next_s   = s;
    next_s.op_valid = 1'b0;
    next_s.sck_d    = sck_q;
    sck_rise = sck_q && !s.sck_d;
    sck_fall = !sck_q && s.sck_d;

    // internal operation timer; completion clears latch as needed
    if (s.busy) begin
      if (s.timer == 24'h0) begin
        next_s.busy = 1'b0;
        if (s.clr_wel_done) next_s.write_enable_latch = 1'b0;
        if (s.aai_exit) begin
          next_s.auto_increment_program_mode = 1'b0;
          next_s.write_enable_latch = 1'b0;
        end
      end else begin
        next_s.timer = s.timer - 24'h1;
      end
    end

    if (cs_q) begin
      // chip select high: execute only a whole instruction
      next_s.frame = F_IDLE;
      next_s.so_en = 1'b0;
      if (s.frame == F_PAYLOAD && s.bit_cnt == 3'h0 &&
          s.rx_cnt == need_bytes(s.opcode, s.auto_increment_program_mode) &&
          (!s.auto_increment_program_mode || s.opcode == OPC_AUTO_INC_PROG || s.opcode == OPC_WRITE_DISABLE)) begin
        addr = s.payload[ADDR_W-1:0];
        unique case (s.opcode)
          OPC_WRITE_ENABLE:  next_s.write_enable_latch = 1'b1;
          OPC_WRITE_DISABLE: begin
            next_s.write_enable_latch = 1'b0;
            next_s.auto_increment_program_mode = 1'b0;
          end
          OPC_STATUS_WR_EN:  next_s.ewsr = 1'b1;
          OPC_STATUS_WRITE:  begin
            if (s.write_enable_latch || s.ewsr) begin
              if (wp_q || !s.lock) begin
                next_s.bp   = s.payload[ST_BP_MSB:ST_BP_LSB];
                next_s.lock = s.payload[ST_LOCK_POS];
              end
              next_s.write_enable_latch  = 1'b0;
              next_s.ewsr = 1'b0;
            end
          end
          OPC_BYTE_PROGRAM: begin
            tgt = s.payload[ADDR_W+7:8];
            if (s.write_enable_latch && !prot_hit(s.bp, tgt)) begin
              start = 1'b1;
              next_s.op_kind = OP_BYTE_PROG;
              next_s.op_data = {8'h00, s.payload[7:0]};
              next_s.timer   = PROG_CYCLES - 24'h1;
            end
          end
          OPC_AUTO_INC_PROG: begin
            tgt = s.auto_increment_program_mode ? s.aai_addr : {s.payload[ADDR_W+15:17], 1'b0};
            if (s.write_enable_latch && !prot_hit(s.bp, tgt)) begin
              start = 1'b1;
              next_s.auto_increment_program_mode      = 1'b1;
              next_s.op_kind  = OP_AAI_WORD;
              next_s.op_data  = s.payload[15:0];
              next_s.timer    = PROG_CYCLES - 24'h1;
              next_s.aai_addr = tgt + ADDR_W'(2);
              // stop at the top of the array or at the protected range
              next_s.aai_exit = (&tgt[ADDR_W-1:1]) || prot_hit(s.bp, tgt + ADDR_W'(2));
            end
          end
          OPC_SECTOR_ERASE, OPC_BLOCK32_ERASE, OPC_BLOCK64_ERASE: begin
            tgt = addr;
            if (s.write_enable_latch && !prot_hit(s.bp, tgt)) begin
              start = 1'b1;
              next_s.op_kind = (s.opcode == OPC_SECTOR_ERASE)  ? OP_SECTOR :
                               (s.opcode == OPC_BLOCK32_ERASE) ? OP_BLOCK32 : OP_BLOCK64;
              next_s.op_data = 16'h0000;
              next_s.timer   = ERASE_CYCLES - 24'h1;
            end
          end
          OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B: begin
            if (s.write_enable_latch && s.bp == 4'h0) begin
              start = 1'b1;
              next_s.op_kind = OP_CHIP;
              next_s.op_data = 16'h0000;
              next_s.timer   = CHIP_CYCLES - 24'h1;
            end
          end
          default: ;
        endcase
        if (start) begin
          next_s.busy         = 1'b1;
          next_s.op_valid     = 1'b1;
          next_s.op_addr      = tgt;
          next_s.clr_wel_done = (s.opcode != OPC_AUTO_INC_PROG);
          if (s.opcode != OPC_AUTO_INC_PROG) next_s.aai_exit = 1'b0;
        end
      end
    end else if (s.frame == F_IDLE) begin
      // chip select fall opens a new instruction
      next_s.frame   = F_OPCODE;
      next_s.bit_cnt = 3'h0;
      next_s.rx_cnt  = 3'h0;
      next_s.obit    = 3'h0;
    end else if (sck_rise && (s.frame == F_OPCODE || s.frame == F_PAYLOAD)) begin
      sh             = {s.shift[6:0], si_q};
      next_s.shift   = sh;
      next_s.bit_cnt = s.bit_cnt + 3'h1;
      if (s.bit_cnt == 3'h7) begin
        if (s.frame == F_OPCODE) begin
          next_s.opcode = sh;
          // while busy only status polling is honoured
          if (sh == OPC_STATUS_READ)  next_s.frame = F_STATUS;
          else if (s.busy)            next_s.frame = F_DISCARD;
          else                        next_s.frame = F_PAYLOAD;
        end else begin
          next_s.payload = {s.payload[31:0], sh};
          if (s.rx_cnt != 3'h6) next_s.rx_cnt = s.rx_cnt + 3'h1;
        end
      end
    end else if (sck_fall && s.frame == F_STATUS) begin
      // reload the live status at every byte boundary
      next_s.so_en = 1'b1;
      next_s.obit  = s.obit + 3'h1;
      if (s.obit == 3'h0) begin
        next_s.so     = st_now[7];
        next_s.out_sh = {st_now[6:0], 1'b0};
      end else begin
        next_s.so     = s.out_sh[7];
        next_s.out_sh = {s.out_sh[6:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s      <= '0;
      s.bp   <= BP_RESET;
      s.sck_d <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign so          = s.so;
  assign so_en       = s.so_en;
  assign status_word = pack_status(s);
  assign op_valid    = s.op_valid;
  assign op_kind     = s.op_kind;
  assign op_addr     = s.op_addr;
  assign op_data     = s.op_data;

endmodule
`default_nettype wire

//--- dv/sfsp_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// status and protection checker
// ****
module sfsp_chk
  import sflash_pkg::*;
#(
  parameter int          ADDR_W       = ADDR_WIDTH,
  parameter logic [23:0] PROG_CYCLES  = PROG_CYCLES_DEF,
  parameter logic [23:0] ERASE_CYCLES = ERASE_CYCLES_DEF,
  parameter logic [23:0] CHIP_CYCLES  = CHIP_CYCLES_DEF
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // serial pins
  input  wire logic              cs_n,
  input  wire logic              sck,
  input  wire logic              si,
  input  wire logic              wp_n,
  input  wire logic              so,
  input  wire logic              so_en,
  // status and operation request
  input  wire logic [7:0]        status_word,
  input  wire logic              op_valid,
  input  wire logic [2:0]        op_kind,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic [15:0]       op_data
);
  logic      [23:0] busy_cnt;
  logic      [23:0] busy_len;
  wire logic [3:0]  bp = status_word[5:2];
  // upper range covered by a level; the top level bit plays no part
  function automatic logic hit(input logic [2:0] l, input logic [18:0] a);
    return l[2] || (l != 3'h0 && a >= (l == 3'h1 ? 19'h70000 : l == 3'h2 ? 19'h60000 : 19'h40000));
  endfunction
  // busy length bookkeeping, expected length picked from the accepted kind
  always_ff @(posedge core_clk) begin
    busy_cnt <= (rst || !status_word[0]) ? 24'h0 : busy_cnt + 24'h1;
    if (op_valid)
      busy_len <= (op_kind <= OP_AAI_WORD) ? PROG_CYCLES :
                  (op_kind == OP_CHIP) ? CHIP_CYCLES : ERASE_CYCLES;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence sel_idle;
    cs_n [*4];
  endsequence
  sequence busy_run;
    status_word[0] [*8];
  endsequence
  // reset check must not be masked by the reset itself
  AST_RESET_VAL: assert property (disable iff (1'b0) rst |=> status_word == 8'h1c && !op_valid)
    else $error("status not at power-up value after reset");
  AST_OP_WEL: assert property (op_valid |-> $past(status_word[1]))
    else $error("operation accepted without write enable");
  AST_OP_BUSY: assert property (op_valid |-> busy_run)
    else $error("busy not held after accepted operation");
  AST_BUSY_RISE: assert property ($rose(status_word[0]) |-> op_valid)
    else $error("busy rose without an operation");
  AST_BUSY_LEN: assert property ($fell(status_word[0]) |->
    busy_cnt >= busy_len - 24'h1 && busy_cnt <= busy_len + 24'h1)
    else $error("busy length wrong");
  AST_OP_FREE: assert property (op_valid && op_kind != OP_CHIP |-> !hit(bp[2:0], 19'(op_addr)))
    else $error("operation accepted in protected range");
  AST_CHIP: assert property (op_valid && op_kind == OP_CHIP |-> bp == 4'h0)
    else $error("chip erase accepted with level set");
  AST_LOCK: assert property (status_word[7] && !(wp_n || $past(wp_n) || $past(wp_n, 2) ||
    $past(wp_n, 3)) |=> $stable(status_word[7:2]))
    else $error("locked level bits changed");
  AST_WEL_DONE: assert property ($fell(status_word[0]) && !status_word[6] |-> !status_word[1])
    else $error("write enable kept after completion");
  AST_AAI_RISE: assert property ($rose(status_word[6]) |-> op_valid && op_kind == OP_AAI_WORD)
    else $error("auto-increment flag rose without its operation");
  AST_SO_IDLE: assert property (sel_idle |=> !so_en)
    else $error("output driven while deselected");
endmodule
bind serial_flash_status_protect sfsp_chk #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES), .CHIP_CYCLES(CHIP_CYCLES)) chk (.core_clk(core_clk), .rst(rst),
  .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_en(so_en), .op_data(op_data),
  .status_word(status_word), .op_valid(op_valid), .op_kind(op_kind), .op_addr(op_addr));
`default_nettype wire

//--- dv/spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// serial host model
// ****
module spi_host_model (
  // frame starts placed from this clock
  input  wire logic core_clk,
  // serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so,
  input  wire logic so_en
);
  // select idles high; clock idles low and stands still between frames
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // one frame: nb bits out, then nr bits captured; starts just after a core_clk edge
  task automatic run(input logic [47:0] w, input int nb, input int nr, output logic [15:0] rd);
    rd = 16'h0;
    @(posedge core_clk);
    #2 cs_n = 1'b0;
    for (int i = 0; i < nb + nr; i++) begin
      #80 sck = 1'b0;
      si = (i < nb) ? w[47 - i] : ~si;
      #80 sck = 1'b1;
      if (i >= nb) rd = {rd[14:0], so_en === 1'b1 ? so : 1'bx};
    end
    #80 sck = 1'b0;
    #80 cs_n = 1'b1;
    si = ~si;
    #400;
  endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
  import sflash_pkg::*;
  // short erase times keep the run brief; the program time is longer than the default
  localparam logic [23:0] PC = 24'h000064;
  localparam logic [23:0] EC = 24'h000096;
  localparam logic [23:0] CC = 24'h0000c8;
  localparam logic [7:0]  ER_OPC [5] = '{OPC_SECTOR_ERASE, OPC_BLOCK32_ERASE,
    OPC_BLOCK64_ERASE, OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B};
  localparam logic [2:0]  ER_KIND [5] = '{OP_SECTOR, OP_BLOCK32, OP_BLOCK64, OP_CHIP, OP_CHIP};
  localparam logic [18:0] EDGE [4] = '{19'h3ffff, 19'h40000, 19'h60000, 19'h70000};
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        wp_n     = 1'b1;
  logic        cs_n, sck, si, so, so_en, op_valid;
  logic [7:0]  status_word, exp_st;
  logic [2:0]  op_kind, l_kind;
  logic [18:0] op_addr, l_addr;
  logic [15:0] op_data, rd, l_data;
  int          bad_count = 0;
  int          checks    = 0;
  int          n_ops     = 0;
  always #5 core_clk = ~core_clk;
  serial_flash_status_protect #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC), .CHIP_CYCLES(CC)) dut (
    .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so),
    .so_en(so_en), .status_word(status_word), .op_valid(op_valid), .op_kind(op_kind),
    .op_addr(op_addr), .op_data(op_data));
  spi_host_model host (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
    .so_en(so_en));
  // record each accepted array operation mid-cycle, away from the launching edge
  always @(negedge core_clk) begin
    if (op_valid === 1'b1) begin
      n_ops++;
      l_kind = op_kind;
      l_addr = op_addr;
      l_data = op_data;
    end
  end
  function automatic logic hit(input logic [2:0] l, input logic [18:0] a);
    return l[2] || (l != 3'h0 && a >= (l == 3'h1 ? 19'h70000 : l == 3'h2 ? 19'h60000 : 19'h40000));
  endfunction
  task automatic close_out();
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // status read; two bytes prove the repeat
  task automatic sread();
    host.run({OPC_STATUS_READ, 40'h0}, 8, 16, rd);
    `CHK(rd, {exp_st, exp_st})
    `CHK(status_word, exp_st)
  endtask
  // write enable ahead of a modifying instruction; the expected latch bit is set
  task automatic write_enable_cmd();
    host.run({OPC_WRITE_ENABLE, 40'h0}, 8, 0, rd);
    exp_st[1] = 1'b1;
  endtask
  task automatic wsr(input logic [7:0] d);
    write_enable_cmd();
    host.run({OPC_STATUS_WRITE, d, 32'h0}, 16, 0, rd);
    if (wp_n || !exp_st[7]) {exp_st[7], exp_st[5:2]} = {d[7], d[5:2]};
    exp_st[1] = 1'b0;
    sread();
  endtask
  task automatic do_op(input logic [47:0] w, input int nb, input logic ok,
                       input logic [2:0] k, input logic [18:0] a);
    int n0;
    n0 = n_ops;
    host.run(w, nb, 0, rd);
    `CHK(n_ops - n0, int'(ok))
    if (ok) begin
      `CHK(l_kind, k)
      if (k != OP_CHIP) `CHK(l_addr, a)
      `CHK(status_word[0], 1'b1)
      // nothing but waiting while busy
      for (int i = 0; i < 4000 && status_word[0] !== 1'b0; i++) @(posedge core_clk);
      exp_st[6] = (k == OP_AAI_WORD);
      exp_st[1] = exp_st[6];
    end
    sread();
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    logic [18:0] a;
    logic [7:0]  d8;
    void'($urandom(20627));
    exp_st = 8'h1c;
    repeat (16) @(posedge core_clk);
    #2 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK(status_word, 8'h1c)
    write_enable_cmd();
    sread();
    host.run({OPC_WRITE_DISABLE, 40'h0}, 8, 0, rd);
    exp_st[1] = 1'b0;
    sread();
    host.run({OPC_WRITE_ENABLE, 40'h0}, 5, 0, rd);
    sread();
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk) #2 wp_n = 1'($urandom);
      wsr(8'($urandom));
    end
    @(posedge core_clk) #2 wp_n = 1'b1;
    wsr(8'h9c);
    @(posedge core_clk) #2 wp_n = 1'b0;
    wsr(8'h00);
    @(posedge core_clk) #2 wp_n = 1'b1;
    wsr(8'h80);
    for (int b = 0; b < 8; b++) begin
      wsr({2'b00, 1'($urandom), 3'(b), 2'b00});
      for (int j = 0; j < 4; j++) begin
        a = EDGE[j] | 19'($urandom & 32'hfff);
        d8 = 8'($urandom);
        write_enable_cmd();
        do_op({OPC_BYTE_PROGRAM, 5'h0, a, d8, 8'h0}, 40, !hit(3'(b), a),
          OP_BYTE_PROG, a);
        if (!hit(3'(b), a)) `CHK(l_data, {8'h00, d8})
      end
    end
    wsr(8'h20);
    write_enable_cmd();
    do_op({OPC_CHIP_ERASE_A, 40'h0}, 8, 1'b0, OP_CHIP, 19'h0);
    wsr(8'h00);
    do_op({OPC_SECTOR_ERASE, 24'h012345, 16'h0}, 32, 1'b0, OP_SECTOR, 19'h12345);
    // status-write enable stands in for the latch once
    host.run({OPC_STATUS_WR_EN, 40'h0}, 8, 0, rd);
    host.run({OPC_STATUS_WRITE, 8'h04, 32'h0}, 16, 0, rd);
    exp_st[5:2] = 4'h1;
    sread();
    wsr(8'h00);
    for (int i = 0; i < 5; i++) begin
      a = 19'($urandom);
      write_enable_cmd();
      do_op({ER_OPC[i], 5'h0, a, 16'h0}, i < 3 ? 32 : 8, 1'b1, ER_KIND[i], a);
    end
    write_enable_cmd();
    do_op({OPC_AUTO_INC_PROG, 24'h000100, 16'h1234}, 48, 1'b1, OP_AAI_WORD, 19'h00100);
    `CHK(l_data, 16'h1234)
    do_op({OPC_AUTO_INC_PROG, 16'h5678, 24'h0}, 24, 1'b1, OP_AAI_WORD, 19'h00102);
    `CHK(l_data, 16'h5678)
    // reset in mid-run while auto-increment mode and the latch are set
    @(posedge core_clk) #2 rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #2 rst = 1'b0;
    exp_st = STATUS_RESET;
    repeat (4) @(posedge core_clk);
    `CHK(status_word, STATUS_RESET)
    sread();
    host.run({OPC_WRITE_DISABLE, 40'h0}, 8, 0, rd);
    exp_st[6] = 1'b0;
    exp_st[1] = 1'b0;
    sread();
    close_out();
  end
  // watchdog a little past the expected run of roughly 81k cycles
  initial begin
    #1000000;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
